//--- design/dcb_pkg.sv
// Constants and types shared by the DDR2 column burst block
package dcb_pkg;
	// ---------------------------------------------------------------
	// Command encoding {cs_n, ras_n, cas_n, we_n}
	// ---------------------------------------------------------------
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_ACT = 4'h3;
	// ---------------------------------------------------------------
	// Field positions and widths
	// ---------------------------------------------------------------
	localparam int AP_BIT = 10;
	localparam int COL_W = 9;
	localparam int ADDR_W = 13;
	localparam int DQ_W = 16;
	localparam int LAT_W = 5;
	localparam int TIM_W = 6;
	localparam int DM_W = DQ_W / 8;
	// ---------------------------------------------------------------
	// Burst lengths
	// ---------------------------------------------------------------
	localparam logic [3:0] BL4 = 4'h4;
	localparam logic [3:0] BL8 = 4'h8;
	localparam logic [3:0] PREFETCH_OFS = 4'h2;
	localparam logic [LAT_W-1:0] FIXED_RTP_MIN = 5'h02;
	// ---------------------------------------------------------------
	// Timing figures
	// ---------------------------------------------------------------
	localparam int CLK_PS = 10000;
	localparam int WRAP_MIN_TCK_PS = 1875;
	localparam bit WRAP_SUPPORTED = (CLK_PS >= WRAP_MIN_TCK_PS);
	localparam int PIPE_D = 32;
	// ---------------------------------------------------------------
	// Burst engine states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		DCB_IDLE = 2'b00,
		DCB_PRE = 2'b01,
		DCB_DATA = 2'b10
	} dcb_burst_t;
endpackage

//--- design/dcb_sync.sv
// Two flip-flop synchroniser with asynchronous reset, no clock enable
`timescale 1ns/1ps
module dcb_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
		end
	end
	assign q_o = s2_q;
endmodule

//--- design/dcb_column.sv
// DDR2 column access: posted commands, bursts, masking, auto precharge
// Operation
// - Column commands accepted any time after activate, delayed by AL
// - Read latency equals AL plus CL clocks
// - Write latency equals read latency minus one
// - Read decoded when cs and cas low, ras and we high
// - Strobe low one clock before read data, data edge aligned; an aligned re-issue releases the strobe for that clock instead
// - Write decoded when cs, cas, we low and ras high
// - Write data captured for BL 4 or 8, extra data ignored
// - One mask per byte, blocks write, ignored on reads
// - Read auto precharge at AL+BL/2, held for tRAS and tRTP
// - tRP starts at internal precharge instant
// - Write auto precharge after burst plus tWR, needs tCK>=1.875ns
`timescale 1ns/1ps
module dcb_column #(
	parameter logic [dcb_pkg::TIM_W-1:0] T_RAS_CK = 6'h08,
	parameter logic [dcb_pkg::TIM_W-1:0] T_WR_CK = 6'h03
) (
	// System clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Link clock (ck at the pins)
	input wire logic link_clk_i,
	// Configuration
	input wire logic [dcb_pkg::LAT_W-1:0] cas_lat_i,
	input wire logic [dcb_pkg::LAT_W-1:0] add_lat_i,
	input wire logic bl8_i,
	input wire logic [dcb_pkg::LAT_W-1:0] rtp_ck_i,
	// Command pins
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [1:0] bank_i,
	input wire logic [dcb_pkg::ADDR_W-1:0] addr_i,
	// Data pins
	input wire logic [dcb_pkg::DQ_W-1:0] dq_i,
	input wire logic [dcb_pkg::DM_W-1:0] dm_i,
	output logic [dcb_pkg::DQ_W-1:0] dq_o,
	output logic dq_oe_n_o,
	output logic dqs_o,
	output logic dqs_oe_n_o,
	// Array side, system clock
	input wire logic [dcb_pkg::DQ_W-1:0] rd_data_i,
	output logic rd_req_o,
	output logic [1:0] rd_bank_o,
	output logic [dcb_pkg::COL_W-1:0] rd_col_o,
	output logic wr_en_o,
	output logic [1:0] wr_bank_o,
	output logic [dcb_pkg::COL_W-1:0] wr_col_o,
	output logic [dcb_pkg::DQ_W-1:0] wr_data_o,
	output logic [dcb_pkg::DM_W-1:0] wr_mask_o,
	output logic [3:0] autopre_o
);
	// ---------------------------------------------------------------
	// Link side: command capture and delay line (link clock)
	// ---------------------------------------------------------------
	localparam int PD = dcb_pkg::PIPE_D;
	logic [3:0] cmd;
	logic is_rd;
	logic is_wr;
	logic [PD-1:0] rd_line_q, rd_line_d;
	logic [PD-1:0] wr_line_q, wr_line_d;
	logic ev_tgl_q, ev_tgl_d;
	logic ev_wr_q, ev_wr_d;
	logic ev_ap_q, ev_ap_d;
	logic [1:0] ev_bank_q, ev_bank_d;
	logic [dcb_pkg::COL_W-1:0] ev_col_q, ev_col_d;
	logic [dcb_pkg::LAT_W-1:0] rl;
	logic [dcb_pkg::LAT_W-1:0] wl;
	logic [dcb_pkg::LAT_W-1:0] cas_s, add_s;
	logic bl8_s;

	dcb_sync #(.W(2 * dcb_pkg::LAT_W + 1)) u_cfg_sync (
		.clk_i(link_clk_i),
		.resetn_i(resetn_i),
		.d_i({cas_lat_i, add_lat_i, bl8_i}),
		.q_o({cas_s, add_s, bl8_s})
	);

	assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
	assign is_rd = (cmd == dcb_pkg::CMD_READ);
	assign is_wr = (cmd == dcb_pkg::CMD_WRITE);
	assign rl = add_s + cas_s;
	assign wl = rl - 5'h01;

	always_comb begin
		rd_line_d = {rd_line_q[PD-2:0], 1'b0};
		wr_line_d = {wr_line_q[PD-2:0], 1'b0};
		ev_tgl_d = ev_tgl_q;
		ev_wr_d = ev_wr_q;
		ev_ap_d = ev_ap_q;
		ev_bank_d = ev_bank_q;
		ev_col_d = ev_col_q;
		// Posted: command shifted down the delay line, tapped at RL-2 (read) or WL-2 (write)
		if (is_rd) begin
			rd_line_d[0] = 1'b1;
		end
		if (is_wr) begin
			wr_line_d[0] = 1'b1;
		end
		if (is_rd || is_wr) begin
			ev_tgl_d = ~ev_tgl_q;
			ev_wr_d = is_wr;
			ev_ap_d = addr_i[dcb_pkg::AP_BIT];
			ev_bank_d = bank_i;
			ev_col_d = addr_i[dcb_pkg::COL_W-1:0];
		end
	end

	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_line_q <= '0;
			wr_line_q <= '0;
			ev_tgl_q <= 1'b0;
			ev_wr_q <= 1'b0;
			ev_ap_q <= 1'b0;
			ev_bank_q <= 2'h0;
			ev_col_q <= '0;
		end else begin
			rd_line_q <= rd_line_d;
			wr_line_q <= wr_line_d;
			ev_tgl_q <= ev_tgl_d;
			ev_wr_q <= ev_wr_d;
			ev_ap_q <= ev_ap_d;
			ev_bank_q <= ev_bank_d;
			ev_col_q <= ev_col_d;
		end
	end

	// ---------------------------------------------------------------
	// Link side: burst engine for strobe and data
	// ---------------------------------------------------------------
	logic rd_pre, wr_pre;
	dcb_pkg::dcb_burst_t st_q, st_d;
	logic st_rd_q, st_rd_d;
	logic [3:0] beat_q, beat_d;
	logic [3:0] blen;
	logic [dcb_pkg::DQ_W-1:0] dqo_q, dqo_d;
	logic doe_n_q, doe_n_d;
	logic dqs_q, dqs_d;
	logic soe_n_q, soe_n_d;
	logic wv_tgl_q, wv_tgl_d;
	// Write beats parked until the system side has taken them
	logic [2:0] wp_q, wp_d;
	logic wv_we;
	logic wv_last;
	logic [dcb_pkg::DQ_W+dcb_pkg::DM_W:0] wbuf_q [8];
	logic [dcb_pkg::DQ_W-1:0] rd_s;

	dcb_sync #(.W(dcb_pkg::DQ_W)) u_rd_sync (
		.clk_i(link_clk_i),
		.resetn_i(resetn_i),
		.d_i(rd_data_i),
		.q_o(rd_s)
	);

	assign blen = bl8_s ? dcb_pkg::BL8 : dcb_pkg::BL4;
	// Preamble one clock ahead of first data
	assign rd_pre = (rl >= 5'h02) && rd_line_q[rl - 5'h02];
	assign wr_pre = (wl >= 5'h02) && wr_line_q[wl - 5'h02];

	always_comb begin
		st_d = st_q;
		st_rd_d = st_rd_q;
		beat_d = beat_q;
		dqo_d = dqo_q;
		doe_n_d = 1'b1;
		dqs_d = 1'b0;
		soe_n_d = 1'b1;
		wv_tgl_d = wv_tgl_q;
		wp_d = wp_q;
		wv_we = 1'b0;
		wv_last = 1'b0;
		case (st_q)
			dcb_pkg::DCB_IDLE: begin
				if (rd_pre) begin
					st_d = dcb_pkg::DCB_PRE;
					st_rd_d = 1'b1;
					soe_n_d = 1'b0;
				end else if (wr_pre) begin
					st_d = dcb_pkg::DCB_PRE;
					st_rd_d = 1'b0;
				end
			end
			dcb_pkg::DCB_PRE: begin
				st_d = dcb_pkg::DCB_DATA;
				beat_d = 4'h0;
				soe_n_d = !st_rd_q;
				doe_n_d = !st_rd_q;
				dqs_d = st_rd_q;
				dqo_d = rd_s;
				// First write word is sampled at write latency
				wv_we = !st_rd_q;
			end
			default: begin
				// Two beats per link clock, one word per link clock
				beat_d = beat_q + 4'h2;
				soe_n_d = !st_rd_q;
				doe_n_d = !st_rd_q;
				dqs_d = st_rd_q;
				dqo_d = rd_s;
				if (beat_q + 4'h2 >= blen) begin
					// Burst over: later data on dq ignored
					st_d = dcb_pkg::DCB_IDLE;
					soe_n_d = 1'b1;
					doe_n_d = 1'b1;
					// Aligned re-issue goes back to PRE, with dq and strobe released for one clock
					if ((st_rd_q && rd_pre) || (!st_rd_q && wr_pre)) begin
						st_d = dcb_pkg::DCB_PRE;
					end
				end else begin
					wv_we = !st_rd_q;
					wv_last = (beat_q + 4'h4 >= blen);
				end
			end
		endcase
		if (wv_we) begin
			wv_tgl_d = ~wv_tgl_q;
			wp_d = wp_q + 3'h1;
		end
	end

	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= dcb_pkg::DCB_IDLE;
			st_rd_q <= 1'b0;
			beat_q <= 4'h0;
			dqo_q <= '0;
			doe_n_q <= 1'b1;
			dqs_q <= 1'b0;
			soe_n_q <= 1'b1;
			wv_tgl_q <= 1'b0;
			wp_q <= 3'h0;
		end else begin
			st_q <= st_d;
			st_rd_q <= st_rd_d;
			beat_q <= beat_d;
			dqo_q <= dqo_d;
			doe_n_q <= doe_n_d;
			dqs_q <= dqs_d;
			soe_n_q <= soe_n_d;
			wv_tgl_q <= wv_tgl_d;
			wp_q <= wp_d;
		end
	end

	// Burst buffer; pointers on both sides keep it in step
	always_ff @(posedge link_clk_i) begin
		if (wv_we) begin
			wbuf_q[wp_q] <= {wv_last, dm_i, dq_i};
		end
	end

	assign dq_o = dqo_q;
	assign dq_oe_n_o = doe_n_q;
	assign dqs_o = dqs_q;
	assign dqs_oe_n_o = soe_n_q;

	// ---------------------------------------------------------------
	// System side: receive events across the crossing
	// ---------------------------------------------------------------
	logic ev_s, wv_s;
	logic ev_seen_q, ev_seen_d;
	logic wv_seen_q, wv_seen_d;
	logic [dcb_pkg::LAT_W-1:0] add_c, rtp_c;
	logic bl8_c;

	dcb_sync #(.W(2)) u_tgl_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.d_i({ev_tgl_q, wv_tgl_q}),
		.q_o({ev_s, wv_s})
	);
	dcb_sync #(.W(2 * dcb_pkg::LAT_W + 1)) u_cfg_sync_c (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.d_i({add_lat_i, rtp_ck_i, bl8_i}),
		.q_o({add_c, rtp_c, bl8_c})
	);

	// ---------------------------------------------------------------
	// System side: array requests and auto precharge timers
	// ---------------------------------------------------------------
	localparam int TIM_W_L = dcb_pkg::TIM_W;
	logic [TIM_W_L-1:0] ap_cnt_q [4];
	logic [TIM_W_L-1:0] ap_cnt_d [4];
	logic [3:0] ap_q, ap_d;
	logic [3:0] apo_q, apo_d;
	logic rdr_q, rdr_d;
	logic wre_q, wre_d;
	logic [1:0] bk_q, bk_d;
	logic [dcb_pkg::COL_W-1:0] col_q, col_d;
	logic [dcb_pkg::COL_W-1:0] wcol_q, wcol_d;
	logic [dcb_pkg::DQ_W-1:0] wd_q, wd_d;
	logic [dcb_pkg::DM_W-1:0] wm_q, wm_d;
	logic [TIM_W_L-1:0] rd_ap_dly;
	logic [2:0] rp_q, rp_d;
	logic wap_q, wap_d;
	logic [1:0] wapb_q, wapb_d;
	logic [dcb_pkg::COL_W-1:0] nxt_col_q, nxt_col_d;
	logic wlast;
	logic [dcb_pkg::LAT_W-1:0] rtp_eff;

	// Read AP at AL+BL/2, pushed out by tRTP from AL(+2) and tRAS
	assign rtp_eff = (rtp_c > dcb_pkg::FIXED_RTP_MIN) ?
		rtp_c : dcb_pkg::FIXED_RTP_MIN;
	always_comb begin
		rd_ap_dly = TIM_W_L'(add_c) + (bl8_c ? 6'h04 : 6'h02);
		if (TIM_W_L'(add_c) + (bl8_c ? 6'h02 : 6'h00) + TIM_W_L'(rtp_eff)
			> rd_ap_dly) begin
			rd_ap_dly = TIM_W_L'(add_c) + (bl8_c ? 6'h02 : 6'h00)
				+ TIM_W_L'(rtp_eff);
		end
		if (T_RAS_CK > rd_ap_dly) begin
			rd_ap_dly = T_RAS_CK;
		end
	end
	always_comb begin
		ev_seen_d = ev_s;
		wv_seen_d = wv_s;
		rdr_d = 1'b0;
		wre_d = 1'b0;
		bk_d = bk_q;
		col_d = col_q;
		wcol_d = wcol_q;
		wd_d = wd_q;
		wm_d = wm_q;
		ap_d = ap_q;
		apo_d = 4'h0;
		rp_d = rp_q;
		wap_d = wap_q;
		wapb_d = wapb_q;
		nxt_col_d = nxt_col_q;
		wlast = 1'b0;
		for (int b = 0; b < 4; b++) begin
			ap_cnt_d[b] = ap_cnt_q[b];
			if (ap_q[b]) begin
				if (ap_cnt_q[b] == '0) begin
					ap_d[b] = 1'b0;
					apo_d[b] = 1'b1;
				end else begin
					ap_cnt_d[b] = ap_cnt_q[b] - 6'h01;
				end
			end
		end
		if (wv_s != wv_seen_q) begin
			wre_d = 1'b1;
			{wlast, wm_d, wd_d} = wbuf_q[rp_q];
			wcol_d = nxt_col_q;
			nxt_col_d = nxt_col_q + 9'h001;
			rp_d = rp_q + 3'h1;
			// Write AP timer starts once the burst is complete
			if (wlast && wap_q) begin
				wap_d = 1'b0;
				ap_d[wapb_q] = 1'b1;
				ap_cnt_d[wapb_q] = T_WR_CK;
			end
		end
		if (ev_s != ev_seen_q) begin
			bk_d = ev_bank_q;
			col_d = ev_col_q;
			nxt_col_d = ev_col_q;
			rdr_d = !ev_wr_q;
			if (ev_ap_q && !ev_wr_q) begin
				ap_d[ev_bank_q] = 1'b1;
				ap_cnt_d[ev_bank_q] = rd_ap_dly;
			end
			wap_d = ev_ap_q && ev_wr_q && dcb_pkg::WRAP_SUPPORTED;
			wapb_d = ev_bank_q;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ev_seen_q <= 1'b0;
			wv_seen_q <= 1'b0;
			rdr_q <= 1'b0;
			wre_q <= 1'b0;
			bk_q <= 2'h0;
			col_q <= '0;
			wcol_q <= '0;
			wd_q <= '0;
			wm_q <= '0;
			ap_q <= 4'h0;
			apo_q <= 4'h0;
			rp_q <= 3'h0;
			wap_q <= 1'b0;
			wapb_q <= 2'h0;
			nxt_col_q <= '0;
			for (int b = 0; b < 4; b++) begin
				ap_cnt_q[b] <= '0;
			end
		end else if (ce_i) begin
			ev_seen_q <= ev_seen_d;
			wv_seen_q <= wv_seen_d;
			rdr_q <= rdr_d;
			wre_q <= wre_d;
			bk_q <= bk_d;
			col_q <= col_d;
			wcol_q <= wcol_d;
			wd_q <= wd_d;
			wm_q <= wm_d;
			ap_q <= ap_d;
			apo_q <= apo_d;
			rp_q <= rp_d;
			wap_q <= wap_d;
			wapb_q <= wapb_d;
			nxt_col_q <= nxt_col_d;
			for (int b = 0; b < 4; b++) begin
				ap_cnt_q[b] <= ap_cnt_d[b];
			end
		end
	end

	assign rd_req_o = rdr_q;
	assign rd_bank_o = bk_q;
	assign rd_col_o = col_q;
	assign wr_en_o = wre_q;
	assign wr_bank_o = bk_q;
	assign wr_col_o = wcol_q;
	assign wr_data_o = wd_q;
	assign wr_mask_o = wm_q;
	assign autopre_o = apo_q;
endmodule

//--- verification/dcb_column_properties.sv
// Concurrent checks on the column burst block ports
`timescale 1ns/1ps
module dcb_column_checker (
	// Clocks and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic link_clk_i,
	// Configuration
	input wire logic [dcb_pkg::LAT_W-1:0] cas_lat_i,
	input wire logic [dcb_pkg::LAT_W-1:0] add_lat_i,
	input wire logic bl8_i,
	// Command pins
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	// Pin outputs and array side
	input wire logic dq_oe_n_o,
	input wire logic dqs_o,
	input wire logic dqs_oe_n_o,
	input wire logic [3:0] autopre_o
);
	logic rd_cmd;
	logic wr_cmd;
	logic [7:0] rl;
	logic [7:0] since_rd_q;
	logic [7:0] since_rd_d;
	logic [3:0] run_q;
	logic [3:0] run_d;
	assign rd_cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i} == dcb_pkg::CMD_READ;
	assign wr_cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i} == dcb_pkg::CMD_WRITE;
	assign rl = {3'h0, add_lat_i} + {3'h0, cas_lat_i};
	// Link cycles since last read, length of current data run
	always_comb begin
		since_rd_d = since_rd_q + {7'h00, since_rd_q != 8'hff};
		if (rd_cmd) begin
			since_rd_d = 8'h00;
		end
		run_d = dq_oe_n_o ? 4'h0 : run_q + 4'h1;
	end
	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			since_rd_q <= 8'hff;
			run_q <= 4'h0;
		end else begin
			since_rd_q <= since_rd_d;
			run_q <= run_d;
		end
	end
	rd_preamble_a: assert property (
		@(posedge link_clk_i) disable iff (!resetn_i)
		$fell(dqs_oe_n_o) |-> since_rd_q == rl - 8'h01)
		else $error("strobe preamble not one clock before latency");
	rd_latency_a: assert property (
		@(posedge link_clk_i) disable iff (!resetn_i)
		$fell(dq_oe_n_o) |-> since_rd_q == rl)
		else $error("read data not at read latency");
	preamble_low_a: assert property (
		@(posedge link_clk_i) disable iff (!resetn_i)
		$fell(dq_oe_n_o) |-> $past(!dqs_oe_n_o && !dqs_o))
		else $error("no low strobe before read data");
	data_strobe_a: assert property (
		@(posedge link_clk_i) disable iff (!resetn_i)
		!dq_oe_n_o |-> !dqs_oe_n_o && dqs_o)
		else $error("read data without strobe");
	burst_len_a: assert property (
		@(posedge link_clk_i) disable iff (!resetn_i)
		$rose(dq_oe_n_o) |-> run_q == (bl8_i ? 4'h4 : 4'h2))
		else $error("read burst of wrong length");
	strobe_release_a: assert property (
		@(posedge link_clk_i) disable iff (!resetn_i)
		$rose(dqs_oe_n_o) |-> $rose(dq_oe_n_o))
		else $error("strobe released apart from data");
	wr_no_drive_a: assert property (
		@(posedge link_clk_i) disable iff (!resetn_i)
		wr_cmd && dq_oe_n_o |=> dq_oe_n_o [*4])
		else $error("data driven after write command");
	autopre_pulse_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		|autopre_o |=> autopre_o == 4'h0)
		else $error("auto precharge pulse too long");
	rd_seen_c: cover property (@(posedge link_clk_i) rd_cmd);
	wr_seen_c: cover property (@(posedge link_clk_i) wr_cmd);
	ap_seen_c: cover property (@(posedge clk_i) |autopre_o);
endmodule

bind dcb_column dcb_column_checker chk_u (.clk_i(clk_i),
	.resetn_i(resetn_i), .link_clk_i(link_clk_i), .cas_lat_i(cas_lat_i),
	.add_lat_i(add_lat_i), .bl8_i(bl8_i), .cs_n_i(cs_n_i),
	.ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
	.dq_oe_n_o(dq_oe_n_o), .dqs_o(dqs_o), .dqs_oe_n_o(dqs_oe_n_o),
	.autopre_o(autopre_o));

//--- verification/dcb_ctrl_model.sv
// Memory controller model driving command and write data pins
`timescale 1ns/1ps
module dcb_ctrl_model (
	// Link clock
	input wire logic link_clk_i,
	// Command pins
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic [1:0] bank_o,
	output logic [dcb_pkg::ADDR_W-1:0] addr_o,
	// Write data
	output logic [dcb_pkg::DQ_W-1:0] dq_o,
	output logic [dcb_pkg::DM_W-1:0] dm_o
);
	initial begin
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
		bank_o = 2'h0;
		addr_o = 13'h0000;
		dq_o = 16'h0000;
		dm_o = 2'h0;
	end
	// One command for one link clock, then NOP; returns at its edge
	task automatic cmd(input logic [3:0] c, input logic [1:0] b,
		input logic [dcb_pkg::ADDR_W-1:0] a);
		@(posedge link_clk_i);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
		bank_o <= b;
		addr_o <= a;
		@(posedge link_clk_i);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h7;
		addr_o <= ~a;
	endtask
	// Whole burst from write latency on, plus one stray word
	task automatic wburst(input int wl, input int n,
		input logic [15:0] d0, input logic [1:0] m);
		logic [15:0] d;
		d = d0;
		repeat (wl - 1) @(posedge link_clk_i);
		for (int i = 0; i <= n; i++) begin
			d = d0 + 16'(i);
			dq_o <= d;
			dm_o <= (i == n) ? 2'h0 : m;
			@(posedge link_clk_i);
		end
		dq_o <= ~d;
		dm_o <= 2'h0;
	endtask
endmodule

//--- verification/dcb_column_tb.sv
// Self-checking bench for the DDR2 column burst block
`timescale 1ns/1ps
module dcb_column_tb;
	logic clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [4:0] cl = 5'h05;
	logic [4:0] al = 5'h00;
	logic bl8 = 1'b0;
	logic cs_n, ras_n, cas_n, we_n;
	logic [1:0] bank, dm, rd_bank, wr_bank, last_bank, wr_mask;
	logic [12:0] addr;
	logic [15:0] dq_in, dq_o, wr_data;
	logic [15:0] rd_word = 16'h5aa5;
	logic dq_oe_n, dqs, dqs_oe_n, rd_req, wr_en;
	logic [8:0] rd_col, wr_col, last_col;
	logic [3:0] autopre, ap_or = 4'h0;
	logic [28:0] wq[$];
	int bad_count = 0;
	int cmp_count = 0;
	initial forever #5 clk_i = ~clk_i;
	initial begin
		#3;
		forever #6 link_clk_i = ~link_clk_i;
	end
	dcb_ctrl_model ctl_u (.link_clk_i(link_clk_i), .cs_n_o(cs_n),
		.ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .bank_o(bank),
		.addr_o(addr), .dq_o(dq_in), .dm_o(dm));
	dcb_column dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
		.link_clk_i(link_clk_i), .cas_lat_i(cl), .add_lat_i(al),
		.bl8_i(bl8), .rtp_ck_i(5'h02), .cs_n_i(cs_n), .ras_n_i(ras_n),
		.cas_n_i(cas_n), .we_n_i(we_n), .bank_i(bank), .addr_i(addr),
		.dq_i(dq_in), .dm_i(dm), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n),
		.dqs_o(dqs), .dqs_oe_n_o(dqs_oe_n), .rd_data_i(rd_word),
		.rd_req_o(rd_req), .rd_bank_o(rd_bank), .rd_col_o(rd_col),
		.wr_en_o(wr_en), .wr_bank_o(wr_bank), .wr_col_o(wr_col),
		.wr_data_o(wr_data), .wr_mask_o(wr_mask), .autopre_o(autopre));
	always @(posedge clk_i) begin
		if (wr_en === 1'b1) wq.push_back({wr_bank, wr_col, wr_data, wr_mask});
		if (rd_req === 1'b1) begin
			last_bank <= rd_bank;
			last_col <= rd_col;
		end
		ap_or <= ap_or | autopre;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [1:0] b, input logic ap, input int rl,
		input int half);
		logic sv, dv;
		ctl_u.cmd(dcb_pkg::CMD_READ, b, {2'h0, ap, 1'b0, 9'h020});
		// Next command only once the whole burst is out
		for (int k = 1; k <= rl + half + 1; k++) begin
			@(posedge link_clk_i);
			#1;
			sv = k >= rl - 1 && k < rl + half;
			dv = k >= rl && k < rl + half;
			check({15'h0, dqs_oe_n}, {15'h0, !sv});
			check({15'h0, dq_oe_n}, {15'h0, !dv});
			if (sv) check({15'h0, dqs}, {15'h0, dv});
			if (dv) check(dq_o, rd_word);
		end
		repeat (10) @(posedge clk_i);
		check({14'h0, last_bank}, {14'h0, b});
		check({7'h0, last_col}, 16'h0020);
	endtask
	task automatic wr(input logic [1:0] b, input logic ap, input int wl,
		input int half, input logic [1:0] m);
		ctl_u.cmd(dcb_pkg::CMD_WRITE, b, {2'h0, ap, 1'b0, 9'h040});
		ctl_u.wburst(wl, half, 16'h3c00, m);
		repeat (20) @(posedge clk_i);
		check(16'(wq.size()), 16'(half));
		for (int i = 0; i < half && i < wq.size(); i++) begin
			check(wq[i][17:2], 16'h3c00 + 16'(i));
			check({14'h0, wq[i][1:0]}, {14'h0, m});
			check({14'h0, wq[i][28:27]}, {14'h0, b});
			check({7'h0, wq[i][26:18]}, 16'h0040 + 16'(i));
		end
		wq.delete();
	endtask
	// Long gap keeps every precharge and reactivation spacing
	task automatic ap_check(input logic [3:0] exp);
		repeat (60) @(posedge clk_i);
		#1;
		check({12'h0, ap_or}, {12'h0, exp});
		ap_or = 4'h0;
	endtask
	task automatic act(input logic [1:0] b);
		ctl_u.cmd(dcb_pkg::CMD_ACT, b, 13'h0000);
		// Without AL the column command waits out the activate delay
		if (al == 5'h00) repeat (4) @(posedge link_clk_i);
	endtask
	task automatic final_report();
		$display("Compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#50000;
		bad_count++;
		final_report();
	end
	initial begin
		int rl, half;
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		for (int c = 0; c < 2; c++) begin
			@(posedge clk_i);
			al <= (c == 0) ? 5'h00 : 5'h03;
			cl <= (c == 0) ? 5'h05 : 5'h04;
			bl8 <= (c == 1);
			repeat (10) @(posedge clk_i);
			rl = al + cl;
			half = bl8 ? 4 : 2;
			act(2'h1);
			rd(2'h1, 1'b0, rl, half);
			wr(2'h1, 1'b0, rl - 1, half, 2'(c + 1));
			ap_check(4'h0);
			act(2'h2);
			rd(2'h2, 1'b1, rl, half);
			ap_check(4'h4);
			act(2'h3);
			wr(2'h3, 1'b1, rl - 1, half, 2'h0);
			ap_check(4'h8);
		end
		final_report();
	end
endmodule
